// file: logic/dpoc_pkg.sv
package dpoc_pkg;

  // processor port geometry
  localparam int ADDR_W = 8;  // register address width
  localparam int DATA_W = 8;  // register data width

  // register offsets on the processor port
  localparam logic [7:0] OFS_OUTPUT_CONFIG_FOUR = 8'h63;
  localparam logic [7:0] OFS_DPLL_CONFIG_ONE = 8'h64;
  localparam logic [7:0] OFS_DPLL_LOOP_BANDWIDTH = 8'h66;
  localparam logic [7:0] OFS_DPLL_CONFIG_TWO = 8'h6A;

  // reset values; the rate bit of config one is replaced by the strap
  localparam logic [7:0] RST_OUTPUT_CONFIG_FOUR = 8'hF6;
  localparam logic [7:0] RST_DPLL_CONFIG_ONE = 8'h01;
  localparam logic [7:0] RST_DPLL_LOOP_BANDWIDTH = 8'h00;
  localparam logic [7:0] RST_DPLL_CONFIG_TWO = 8'h13;

  // field positions
  localparam int BIT_OUT_ENABLE = 5;  // in output_config_four
  localparam int BIT_AUTO_SQUELCH = 6;  // in dpll_config_one
  localparam int BIT_RATE_SELECT = 4;  // in dpll_config_one
  localparam int FREQ_MSB = 3;  // dpll_frequency_code in dpll_config_one
  localparam int BW_MSB = 1;  // dpll_loop_bandwidth_sel
  localparam int DAMPING_SELECT_MSB = 2;  // damping_select in dpll_config_two

  // loop bandwidth codes and their value in hertz
  localparam logic [1:0] BW_CODE_18 = 2'h0;
  localparam logic [1:0] BW_CODE_35 = 2'h1;
  localparam logic [1:0] BW_CODE_70 = 2'h2;
  localparam logic [6:0] BW_HZ_18 = 7'h12;
  localparam logic [6:0] BW_HZ_35 = 7'h23;
  localparam logic [6:0] BW_HZ_70 = 7'h46;
  localparam logic [6:0] BW_HZ_NONE = 7'h00;

  // damping codes and damping factor in tenths
  localparam logic [2:0] DAMPING_SELECT_CODE_A = 3'h1;
  localparam logic [2:0] DAMPING_SELECT_CODE_B = 3'h2;
  localparam logic [2:0] DAMPING_SELECT_CODE_C = 3'h3;
  localparam logic [2:0] DAMPING_SELECT_CODE_D = 3'h4;
  localparam logic [2:0] DAMPING_SELECT_CODE_E = 3'h5;
  localparam logic [7:0] DAMPING_SELECT_X10_1P2 = 8'h0C;
  localparam logic [7:0] DAMPING_SELECT_X10_2P5 = 8'h19;
  localparam logic [7:0] DAMPING_SELECT_X10_5 = 8'h32;
  localparam logic [7:0] DAMPING_SELECT_X10_10 = 8'h64;
  localparam logic [7:0] DAMPING_SELECT_X10_20 = 8'hC8;
  localparam logic [7:0] DAMPING_SELECT_X10_NONE = 8'h00;

  // timing: system clock and output clock rates
  localparam logic [63:0] CLK_KHZ = 64'h2710;  // 10000 kHz, 100 ns period
  localparam logic [63:0] RATE_SDH_KHZ = 64'h800;  // 2048 kHz
  localparam logic [63:0] RATE_SONET_KHZ = 64'h608;  // 1544 kHz
  localparam int NCO_BITS = 24;  // phase accumulator width
  localparam logic [63:0] NCO_SPAN = 64'h1 << NCO_BITS;
  localparam logic [23:0] NCO_STEP_SDH =
    24'((RATE_SDH_KHZ * NCO_SPAN + CLK_KHZ / 64'h2) / CLK_KHZ);
  localparam logic [23:0] NCO_STEP_SONET =
    24'((RATE_SONET_KHZ * NCO_SPAN + CLK_KHZ / 64'h2) / CLK_KHZ);

  // strap capture sequence after reset release
  typedef enum logic [1:0] {
    CAP_FILL,
    CAP_SETTLE,
    CAP_TAKE,
    CAP_DONE
  } dpoc_cap_type;

endpackage : dpoc_pkg

// file: logic/dpoc_nco.sv
`timescale 1ns/100ps
// phase accumulator that makes the telecom clock from the system clock;
// its edges land on system clock edges, so it carries up to one period of
// jitter, while the average rate is exact to the accumulator resolution
module dpoc_nco
  import dpoc_pkg::*;
(
  input wire logic sys_clk_i,
  input wire logic rst_b_i,
  input wire logic [NCO_BITS-1:0] step_i,
  output logic clk_o
);
  logic [NCO_BITS-1:0] phase_acc;  // wraps freely

  // accumulate the step every cycle
  always_ff @(posedge sys_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      phase_acc <= '0;
    end
    else
    begin
      phase_acc <= phase_acc + step_i;
    end
  end

  // top bit gives a near-square clock
  always_ff @(posedge sys_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      clk_o <= 1'b0;
    end
    else
    begin
      clk_o <= phase_acc[NCO_BITS-1];
    end
  end
endmodule : dpoc_nco

// file: logic/dpoc_top.sv
// What this block does
// R1 - enable bit five drives clock, else low
// R2 - auto-squelch forces clock low without reference
// R3 - rate bit zero 2048 kHz, one 1544
// R4 - strap pin sets rate bit at reset
// R5 - software keeps frequency code at 0001
// R6 - bandwidth codes 18, 35, 70 Hz
// R7 - low damping codes give 1.2, 2.5, 5
// R8 - codes 100, 101 scale with bandwidth
// R9 - damping code resets to 011
// R10 - software avoids damping codes 000, 110, 111
// R11 - software writes back reset values in spares
`timescale 1ns/100ps
module dpoc_top
  import dpoc_pkg::*;
(
  input wire logic sys_clk_i,
  input wire logic rst_b_i,
  input wire logic [dpoc_pkg::ADDR_W-1:0] cpu_addr_i,
  input wire logic cpu_wr_i,
  input wire logic cpu_rd_i,
  input wire logic [dpoc_pkg::DATA_W-1:0] cpu_wdata_i,
  output logic [dpoc_pkg::DATA_W-1:0] cpu_rdata_o,
  input wire logic network_standard_strap_i,
  input wire logic ref_valid_i,
  output logic secondary_clock_out_o,
  output logic [3:0] dpll_frequency_code_o,
  output logic [1:0] dpll_loop_bandwidth_sel_o,
  output logic [6:0] dpll_bandwidth_hz_o,
  output logic [2:0] damping_select_o,
  output logic [7:0] damping_factor_x10_o
);
  import dpoc_pkg::*;

  // register storage; spare bits keep whatever software writes
  logic [7:0] output_config_four;
  logic [7:0] dpll_config_one;
  logic [7:0] dpll_loop_bandwidth;
  logic [7:0] dpll_config_two;

  // synchronisers for the pins; stage one is read only by stage two
  logic strap_meta;
  logic strap_s;
  logic ref_meta;
  logic ref_s;

  dpoc_cap_type cap_state;  // strap capture progress
  logic strap_loaded;  // pulse when the strap lands in the rate bit
  logic [NCO_BITS-1:0] nco_step;  // step for the selected rate
  logic nco_clk;  // free-running telecom clock
  logic gate_open;  // output allowed this cycle
  logic fresh;  // high through reset and the first cycle after

  // damping factor lookup from code and bandwidth
  function automatic logic [7:0] damping_select_decode(input logic [2:0] code,
                                             input logic [1:0] bw);
    logic [7:0] f;
    f = DAMPING_SELECT_X10_NONE;
    case (code)
      DAMPING_SELECT_CODE_A: f = DAMPING_SELECT_X10_1P2;  // R7
      DAMPING_SELECT_CODE_B: f = DAMPING_SELECT_X10_2P5;  // R7
      DAMPING_SELECT_CODE_C: f = DAMPING_SELECT_X10_5;  // R7
      DAMPING_SELECT_CODE_D: f = (bw == BW_CODE_18) ? DAMPING_SELECT_X10_5 : DAMPING_SELECT_X10_10;  // R8
      DAMPING_SELECT_CODE_E:
      begin
        // R8
        case (bw)
          BW_CODE_18: f = DAMPING_SELECT_X10_5;
          BW_CODE_35: f = DAMPING_SELECT_X10_10;
          BW_CODE_70: f = DAMPING_SELECT_X10_20;
          default: f = DAMPING_SELECT_X10_NONE;
        endcase
      end
      default: f = DAMPING_SELECT_X10_NONE;  // undefined codes give no factor
    endcase
    return f;
  endfunction : damping_select_decode

  // bandwidth code to hertz; the unused code reports zero
  function automatic logic [6:0] bw_decode(input logic [1:0] bw);
    logic [6:0] h;
    h = BW_HZ_NONE;
    case (bw)
      BW_CODE_18: h = BW_HZ_18;  // R6
      BW_CODE_35: h = BW_HZ_35;  // R6
      BW_CODE_70: h = BW_HZ_70;  // R6
      default: h = BW_HZ_NONE;
    endcase
    return h;
  endfunction : bw_decode

  // two-stage synchronisers for the strap and reference-valid pins
  always_ff @(posedge sys_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      strap_meta <= 1'b0;
      strap_s <= 1'b0;
      ref_meta <= 1'b0;
      ref_s <= 1'b0;
    end
    else
    begin
      strap_meta <= network_standard_strap_i;
      strap_s <= strap_meta;
      ref_meta <= ref_valid_i;
      ref_s <= ref_meta;
    end
  end

  // strap capture: async reset may only load constants, so the pin is
  // taken once the synchroniser has filled after release
  always_ff @(posedge sys_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      cap_state <= CAP_FILL;
    end
    else
    begin
      case (cap_state)
        CAP_FILL: cap_state <= CAP_SETTLE;
        CAP_SETTLE: cap_state <= CAP_TAKE;
        CAP_TAKE: cap_state <= CAP_DONE;
        CAP_DONE: cap_state <= CAP_DONE;
        default: cap_state <= CAP_FILL;
      endcase
    end
  end

  assign strap_loaded = (cap_state == CAP_TAKE);

  // output_config_four: plain read/write
  always_ff @(posedge sys_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      output_config_four <= RST_OUTPUT_CONFIG_FOUR;
    end
    else if (cpu_wr_i && cpu_addr_i == OFS_OUTPUT_CONFIG_FOUR)
    begin
      output_config_four <= cpu_wdata_i;
    end
  end

  // dpll_config_one: the strap load beats a same-cycle write to the rate
  // bit, so the pin level is never lost
  always_ff @(posedge sys_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      dpll_config_one <= RST_DPLL_CONFIG_ONE;
    end
    else
    begin
      if (cpu_wr_i && cpu_addr_i == OFS_DPLL_CONFIG_ONE)
      begin
        dpll_config_one <= cpu_wdata_i;
      end
      if (strap_loaded)
      begin
        dpll_config_one[BIT_RATE_SELECT] <= strap_s;  // R4
      end
    end
  end

  // loop bandwidth register
  always_ff @(posedge sys_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      dpll_loop_bandwidth <= RST_DPLL_LOOP_BANDWIDTH;
    end
    else if (cpu_wr_i && cpu_addr_i == OFS_DPLL_LOOP_BANDWIDTH)
    begin
      dpll_loop_bandwidth <= cpu_wdata_i;
    end
  end

  // damping register, reset code 011
  always_ff @(posedge sys_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      dpll_config_two <= RST_DPLL_CONFIG_TWO;  // R9
    end
    else if (cpu_wr_i && cpu_addr_i == OFS_DPLL_CONFIG_TWO)
    begin
      dpll_config_two <= cpu_wdata_i;
    end
  end

  // read data registered one cycle after the strobe; unmapped reads zero
  always_ff @(posedge sys_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      cpu_rdata_o <= '0;
    end
    else if (cpu_rd_i)
    begin
      case (cpu_addr_i)
        OFS_OUTPUT_CONFIG_FOUR: cpu_rdata_o <= output_config_four;
        OFS_DPLL_CONFIG_ONE: cpu_rdata_o <= dpll_config_one;
        OFS_DPLL_LOOP_BANDWIDTH: cpu_rdata_o <= dpll_loop_bandwidth;
        OFS_DPLL_CONFIG_TWO: cpu_rdata_o <= dpll_config_two;
        default: cpu_rdata_o <= '0;
      endcase
    end
  end

  // rate choice; the accumulator keeps running across a change so the
  // switch is phase-continuous rather than restarting from zero
  always_ff @(posedge sys_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      nco_step <= NCO_STEP_SDH;
    end
    else
    begin
      nco_step <= dpll_config_one[BIT_RATE_SELECT] ? NCO_STEP_SONET : NCO_STEP_SDH;  // R3
    end
  end

  dpoc_nco u_nco (
    .sys_clk_i(sys_clk_i),
    .rst_b_i(rst_b_i),
    .step_i(nco_step),
    .clk_o(nco_clk)
  );

  // enable and squelch gate the clock; forcing low can clip a high phase
  assign gate_open = output_config_four[BIT_OUT_ENABLE]  // R1
    && !(dpll_config_one[BIT_AUTO_SQUELCH] && !ref_s);  // R2

  always_ff @(posedge sys_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      secondary_clock_out_o <= 1'b0;
    end
    else
    begin
      secondary_clock_out_o <= gate_open && nco_clk;  // R1 R2
    end
  end

  // settings to the loop filter, registered
  always_ff @(posedge sys_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      dpll_frequency_code_o <= RST_DPLL_CONFIG_ONE[FREQ_MSB:0];
      dpll_loop_bandwidth_sel_o <= RST_DPLL_LOOP_BANDWIDTH[BW_MSB:0];
      dpll_bandwidth_hz_o <= BW_HZ_18;
      damping_select_o <= RST_DPLL_CONFIG_TWO[DAMPING_SELECT_MSB:0];
      damping_factor_x10_o <= DAMPING_SELECT_X10_5;
    end
    else
    begin
      dpll_frequency_code_o <= dpll_config_one[FREQ_MSB:0];
      dpll_loop_bandwidth_sel_o <= dpll_loop_bandwidth[BW_MSB:0];
      dpll_bandwidth_hz_o <= bw_decode(dpll_loop_bandwidth[BW_MSB:0]);  // R6
      damping_select_o <= dpll_config_two[DAMPING_SELECT_MSB:0];
      damping_factor_x10_o <= damping_select_decode(dpll_config_two[DAMPING_SELECT_MSB:0],
                                          dpll_loop_bandwidth[BW_MSB:0]);  // R7 R8
    end
  end

  // first-cycle marker used only by checks
  always_ff @(posedge sys_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      fresh <= 1'b1;
    end
    else
    begin
      fresh <= 1'b0;
    end
  end

  default clocking cb @(posedge sys_clk_i);
  endclocking
  default disable iff (!rst_b_i);

  sequence s_disabled;
    !output_config_four[BIT_OUT_ENABLE];
  endsequence

  sequence s_squelched;
    dpll_config_one[BIT_AUTO_SQUELCH] && !ref_s;
  endsequence

  sequence s_strap_take;
    cap_state == CAP_TAKE;
  endsequence

  a_out_disable_low: assert property (s_disabled |=> !secondary_clock_out_o)  // R1
    else $error("clock out high while disabled");

  a_out_follows_nco: assert property ((gate_open && nco_clk) |=> secondary_clock_out_o)  // R1
    else $error("enabled clock out not following source");

  a_squelch_low: assert property (s_squelched [*2] |=> !secondary_clock_out_o)  // R2
    else $error("clock out high while squelched");

  a_rate_step: assert property (dpll_config_one[BIT_RATE_SELECT]  // R3
    |=> nco_step == NCO_STEP_SONET)
    else $error("wrong step for sonet rate");

  a_strap_taken: assert property (s_strap_take |=>  // R4
    dpll_config_one[BIT_RATE_SELECT] == $past(strap_s) ##1 cap_state == CAP_DONE)
    else $error("strap level not captured");

  a_bw_decode: assert property (dpll_loop_bandwidth[BW_MSB:0] == BW_CODE_35  // R6
    |=> dpll_bandwidth_hz_o == BW_HZ_35)
    else $error("bandwidth 35 Hz not reported");

  a_damping_select_low: assert property (dpll_config_two[DAMPING_SELECT_MSB:0] == DAMPING_SELECT_CODE_B  // R7
    |=> damping_factor_x10_o == DAMPING_SELECT_X10_2P5)
    else $error("damping code 010 not 2.5");

  a_damping_select_scaled: assert property ((dpll_config_two[DAMPING_SELECT_MSB:0] == DAMPING_SELECT_CODE_E  // R8
    && dpll_loop_bandwidth[BW_MSB:0] == BW_CODE_70) |=> damping_factor_x10_o == DAMPING_SELECT_X10_20)
    else $error("damping code 101 at 70 Hz not 20");

  a_damping_select_reset: assert property (fresh |-> dpll_config_two[DAMPING_SELECT_MSB:0] == DAMPING_SELECT_CODE_C  // R9
    && damping_factor_x10_o == DAMPING_SELECT_X10_5)
    else $error("damping not 011 after reset");

endmodule : dpoc_top

// file: testbench/dpoc_top_tb.sv
`timescale 1ns/100ps
module dpoc_top_tb;
  import dpoc_pkg::*;

  logic sys_clk_i = 1'b0; // 10 MHz system clock
  logic rst_b_i = 1'b0; // active low reset
  logic [7:0] cpu_addr_i = 8'h00;
  logic cpu_wr_i = 1'b0;
  logic cpu_rd_i = 1'b0;
  logic [7:0] cpu_wdata_i = 8'h00;
  logic [7:0] cpu_rdata_o;
  logic network_standard_strap_i = 1'b1; // start on the sonet strap
  logic ref_valid_i = 1'b1;
  logic secondary_clock_out_o;
  logic [3:0] dpll_frequency_code_o;
  logic [1:0] dpll_loop_bandwidth_sel_o;
  logic [6:0] dpll_bandwidth_hz_o;
  logic [2:0] damping_select_o;
  logic [7:0] damping_factor_x10_o;
  int err_total = 0; // mismatches seen
  int num_checks = 0; // comparisons made
  int edge_cnt = 0; // rising edges of the telecom clock
  int cyc_cnt = 0; // cycles since time zero, for the hang guard
  logic [7:0] rd_val;

  dpoc_top dpoc_top_i (
    .sys_clk_i(sys_clk_i),
    .rst_b_i(rst_b_i),
    .cpu_addr_i(cpu_addr_i),
    .cpu_wr_i(cpu_wr_i),
    .cpu_rd_i(cpu_rd_i),
    .cpu_wdata_i(cpu_wdata_i),
    .cpu_rdata_o(cpu_rdata_o),
    .network_standard_strap_i(network_standard_strap_i),
    .ref_valid_i(ref_valid_i),
    .secondary_clock_out_o(secondary_clock_out_o),
    .dpll_frequency_code_o(dpll_frequency_code_o),
    .dpll_loop_bandwidth_sel_o(dpll_loop_bandwidth_sel_o),
    .dpll_bandwidth_hz_o(dpll_bandwidth_hz_o),
    .damping_select_o(damping_select_o),
    .damping_factor_x10_o(damping_factor_x10_o)
  );

  // half period of 50 ns
  always #50 sys_clk_i = ~sys_clk_i;

  // the output is registered on the system clock, so it never glitches
  always @(posedge secondary_clock_out_o)
  begin
    edge_cnt <= edge_cnt + 1;
  end

  // hang guard: the whole sequence needs roughly 26000 cycles
  always @(posedge sys_clk_i)
  begin
    cyc_cnt <= cyc_cnt + 1;
    if (cyc_cnt == 60000)
    begin
      err_total = err_total + 1;
      test_done();
    end
  end

  // one comparison, reported at once when it misses
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    num_checks = num_checks + 1;
    if (seen !== exp)
    begin
      err_total = err_total + 1;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  // verdict and end of run
  task automatic test_done();
    if (err_total == 0 && num_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : test_done

  // reset held for ten cycles, then time for the strap capture to land
  task automatic do_reset();
    rst_b_i <= 1'b0;
    repeat (10) @(posedge sys_clk_i);
    rst_b_i <= 1'b1;
    repeat (6) @(posedge sys_clk_i);
  endtask : do_reset

  // one-cycle write strobe; the register takes it at the next edge
  task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk_i);
    cpu_addr_i <= a;
    cpu_wdata_i <= d;
    cpu_wr_i <= 1'b1;
    @(posedge sys_clk_i);
    cpu_wr_i <= 1'b0;
  endtask : reg_wr

  // one-cycle read strobe; data is registered at the strobe edge and
  // stands until the next read, so it is taken at the following edge
  task automatic reg_rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge sys_clk_i);
    cpu_addr_i <= a;
    cpu_rd_i <= 1'b1;
    @(posedge sys_clk_i);
    cpu_rd_i <= 1'b0;
    @(posedge sys_clk_i);
    d = cpu_rdata_o;
  endtask : reg_rd

  // read and compare in one go
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
    reg_rd(a, rd_val);
    check({8'h00, rd_val}, {8'h00, exp});
  endtask : rd_chk

  // counts edges over n cycles; the start phase may cost one edge
  task automatic measure(input int n, input logic [63:0] khz);
    logic [15:0] exp;
    logic [15:0] got;
    exp = 16'((khz * 64'(n)) / CLK_KHZ);
    edge_cnt = 0;
    repeat (n) @(posedge sys_clk_i);
    got = 16'(edge_cnt);
    // a silent output gets no slack: a single edge is a failure
    if (exp != 16'h0 && (got + 16'h1 == exp || got == exp + 16'h1))
      got = exp;
    check(got, exp);
  endtask : measure

  // damping factor in tenths, from the code and the bandwidth code
  function automatic logic [7:0] damping_select_exp(input int d, input int b);
    case (d)
      1: damping_select_exp = 8'h0C;
      2: damping_select_exp = 8'h19;
      3: damping_select_exp = 8'h32;
      4: damping_select_exp = (b == 0) ? 8'h32 : 8'h64;
      5: damping_select_exp = (b == 0) ? 8'h32 : ((b == 1) ? 8'h64 : 8'hC8);
      default: damping_select_exp = 8'h00; // undefined codes report zero
    endcase
  endfunction : damping_select_exp

  initial
  begin
    do_reset();
    // reset image, with the sonet strap latched into the rate bit
    rd_chk(8'h63, 8'hF6);
    rd_chk(8'h64, 8'h11);
    rd_chk(8'h66, 8'h00);
    rd_chk(8'h6A, 8'h13);
    check({12'h000, dpll_frequency_code_o}, 16'h0001);
    check({13'h0000, damping_select_o}, 16'h0003);
    check({8'h00, damping_factor_x10_o}, 16'h0032);
    check({9'h000, dpll_bandwidth_hz_o}, 16'h0012);
    // clock runs at the strapped rate, then at the sdh rate
    measure(5000, RATE_SONET_KHZ);
    reg_wr(8'h64, 8'h01);
    rd_chk(8'h64, 8'h01);
    measure(5000, RATE_SDH_KHZ);
    // unmapped place: write dropped, read gives zero
    reg_wr(8'h65, 8'hAA);
    rd_chk(8'h65, 8'h00);
    // enable off holds the output low
    reg_wr(8'h63, 8'hD6);
    rd_chk(8'h63, 8'hD6);
    repeat (4) @(posedge sys_clk_i);
    measure(300, 64'h0);
    reg_wr(8'h63, 8'hF6);
    // squelch armed and reference lost: output low
    reg_wr(8'h64, 8'h41);
    ref_valid_i <= 1'b0;
    repeat (6) @(posedge sys_clk_i);
    measure(300, 64'h0);
    // reference back: clock returns
    ref_valid_i <= 1'b1;
    repeat (6) @(posedge sys_clk_i);
    measure(5000, RATE_SDH_KHZ);
    // squelch disarmed: a lost reference leaves the clock running
    reg_wr(8'h64, 8'h01);
    ref_valid_i <= 1'b0;
    repeat (6) @(posedge sys_clk_i);
    measure(5000, RATE_SDH_KHZ);
    ref_valid_i <= 1'b1;
    // every bandwidth code against each defined damping code
    for (int b = 0; b < 4; b++)
    begin
      reg_wr(8'h66, 8'(b));
      // only the defined damping codes are written
      for (int d = 1; d < 6; d++)
      begin
        reg_wr(8'h6A, 8'h10 | 8'(d));
        repeat (3) @(posedge sys_clk_i);
        check({14'h0000, dpll_loop_bandwidth_sel_o}, 16'(b));
        check({9'h000, dpll_bandwidth_hz_o},
              (b == 0) ? 16'h0012 : (b == 1) ? 16'h0023 : (b == 2) ? 16'h0046 : 16'h0000);
        check({13'h0000, damping_select_o}, 16'(d));
        if (b < 3)
          check({8'h00, damping_factor_x10_o}, {8'h00, damping_select_exp(d, b)});
      end
      rd_chk(8'h66, 8'(b));
    end
    rd_chk(8'h6A, 8'h15);
    // second reset with the sdh strap
    network_standard_strap_i <= 1'b0;
    do_reset();
    rd_chk(8'h64, 8'h01);
    measure(5000, RATE_SDH_KHZ);
    test_done();
  end

endmodule : dpoc_top_tb
